// ### include/scpa_pkg.sv
// Constants for the stack check and program address block.
// Assumes a classic Wishbone master and a CPU datapath driving strobes.
// How it works
// - Stack pointer addresses first free word, grows up
// - Push writes then increments; pop decrements then reads
// - Call pushes program counter low byte zero-extended
// - Exception push joins status low byte to top
// - Limit unset at reset, bit 0 reads zero
// - Every push address checked against limit; pops check only the floor
// - Push at limit passes, next push traps
// - Stack address below 0800h traps as underflow
// - Table address joins table page above effective address
// - Each table page selects a 32K-word region
// - Table page top bit selects configuration memory
// - Each visibility page selects a 16K-word page
// - Address bit 15 set remaps through visibility page
// - Remap stays in user memory, bit 15 from page
// - Remap read-only, lower word only; table reaches all
// - Word-aligned program addresses force bit 0 zero
// - Table allows unaligned and configuration reads
// - Remap needs visibility enable and address top bit
// - Table writes to configuration memory are refused
package scpa_pkg;
    localparam logic [7:0] SCPA_OFS_SP = 8'h00;
    localparam logic [7:0] SCPA_OFS_LIMIT = 8'h04;
    localparam logic [7:0] SCPA_OFS_TBLPG = 8'h08;
    localparam logic [7:0] SCPA_OFS_PSVPG = 8'h0c;
    localparam logic [7:0] SCPA_OFS_CORE = 8'h10;
    localparam logic [7:0] SCPA_OFS_STAT = 8'h14;
    localparam int SCPA_PSV_BIT = 2;
    localparam int SCPA_CFG_BIT = 7;
    localparam int SCPA_EA_TOP = 15;
    localparam logic [15:0] SCPA_SFR_FLOOR = 16'h0800;
    localparam logic [15:0] SCPA_WORD_STEP = 16'h0002;
    localparam logic [15:0] SCPA_SP_RST = 16'h0800;
    localparam logic [7:0] SCPA_PAGE_RST = 8'h00;
    localparam logic [1:0] SCPA_PUSH_DATA = 2'h0;
    localparam logic [1:0] SCPA_PUSH_CALL = 2'h1;
    localparam logic [1:0] SCPA_PUSH_EXC = 2'h2;
endpackage

// ### rtl/scpa_top.sv
// Stack pointer checking and program space address forming.
// Assumes push, pop and address requests are single-cycle strobes
// synchronous to clk_i, and a classic Wishbone master for registers.
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module scpa_top
    import scpa_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic push_i,
    input wire logic [1:0] push_kind_i,
    input wire logic [15:0] push_data_i,
    input wire logic [7:0] status_low_byte_i,
    input wire logic pop_i,
    output logic mem_we_o,
    output logic mem_re_o,
    output logic [15:0] mem_addr_o,
    output logic [15:0] mem_wdata_o,
    output logic stack_err_trap_o,
    input wire logic pa_req_i,
    input wire logic pa_table_i,
    input wire logic pa_write_i,
    input wire logic pa_word_i,
    input wire logic [15:0] pa_ea_i,
    output logic pa_valid_o,
    output logic [23:0] pa_addr_o,
    output logic pa_cfg_o,
    output logic pa_refuse_o,
    output logic pa_lsw_only_o
);
    typedef struct packed {
        logic [15:0] sp;
        logic [15:0] limit;
        logic [7:0] tblpg;
        logic [7:0] psvpg;
        logic psv_en;
        logic ovf;
        logic unf;
        logic ack;
        logic [31:0] rdata;
        logic mem_we;
        logic mem_re;
        logic [15:0] mem_addr;
        logic [15:0] mem_wdata;
        logic trap;
        logic pa_valid;
        logic [23:0] pa_addr;
        logic pa_cfg;
        logic pa_refuse;
        logic pa_lsw;
    } scpa_state_t;

    scpa_state_t state_reg;
    scpa_state_t state_next;
    logic bus_req;
    logic bus_wr;
    logic [15:0] wr_lo;
    logic [15:0] sp_dec;
    logic push_ovf;
    logic push_unf;
    logic pop_unf;
    logic [15:0] push_word;
    logic psv_hit;

    assign bus_req = wb_cyc_i && wb_stb_i && !state_reg.ack;
    assign bus_wr = bus_req && wb_we_i;
    assign sp_dec = state_reg.sp - SCPA_WORD_STEP;
    // At-limit push is legal; only a pointer past the limit traps as overflow
    assign push_ovf = state_reg.sp > state_reg.limit;
    assign push_unf = state_reg.sp < SCPA_SFR_FLOOR;
    // Checked before the decrement so a pointer near zero cannot wrap past
    assign pop_unf = state_reg.sp < SCPA_SFR_FLOOR + SCPA_WORD_STEP;
    assign psv_hit = state_reg.psv_en && pa_ea_i[SCPA_EA_TOP];

    always_comb
    begin
        // Byte lanes merge into the low half only
        wr_lo = state_reg.sp;
        if (wb_adr_i == SCPA_OFS_LIMIT)
        begin
            wr_lo = state_reg.limit;
        end
        if (wb_sel_i[0])
        begin
            wr_lo[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1])
        begin
            wr_lo[15:8] = wb_dat_i[15:8];
        end
    end

    always_comb
    begin
        case (push_kind_i)
            SCPA_PUSH_CALL: push_word = {8'h00, push_data_i[7:0]};
            SCPA_PUSH_EXC:
                push_word = {status_low_byte_i, push_data_i[7:0]};
            default: push_word = push_data_i;
        endcase
    end

    always_comb
    begin
        state_next = state_reg;
        state_next.ack = bus_req;
        state_next.mem_we = 1'b0;
        state_next.mem_re = 1'b0;
        state_next.trap = 1'b0;
        state_next.pa_valid = 1'b0;
        // Read path
        if (bus_req && !wb_we_i)
        begin
            if (wb_adr_i == SCPA_OFS_SP)
            begin
                state_next.rdata = {16'h0000, state_reg.sp};
            end
            else if (wb_adr_i == SCPA_OFS_LIMIT)
            begin
                state_next.rdata = {16'h0000, state_reg.limit};
            end
            else if (wb_adr_i == SCPA_OFS_TBLPG)
            begin
                state_next.rdata = {24'h000000, state_reg.tblpg};
            end
            else if (wb_adr_i == SCPA_OFS_PSVPG)
            begin
                state_next.rdata = {24'h000000, state_reg.psvpg};
            end
            else if (wb_adr_i == SCPA_OFS_CORE)
            begin
                state_next.rdata = 32'h00000000;
                state_next.rdata[SCPA_PSV_BIT] = state_reg.psv_en;
            end
            else if (wb_adr_i == SCPA_OFS_STAT)
            begin
                state_next.rdata = {30'h0, state_reg.unf, state_reg.ovf};
            end
            else
            begin
                state_next.rdata = 32'h00000000;
            end
        end
        // Write path
        if (bus_wr)
        begin
            if (wb_adr_i == SCPA_OFS_SP)
            begin
                state_next.sp = {wr_lo[15:1], 1'b0};
            end
            else if (wb_adr_i == SCPA_OFS_LIMIT)
            begin
                state_next.limit = {wr_lo[15:1], 1'b0};
            end
            else if (wb_adr_i == SCPA_OFS_TBLPG && wb_sel_i[0])
            begin
                state_next.tblpg = wb_dat_i[7:0];
            end
            else if (wb_adr_i == SCPA_OFS_PSVPG && wb_sel_i[0])
            begin
                state_next.psvpg = wb_dat_i[7:0];
            end
            else if (wb_adr_i == SCPA_OFS_CORE && wb_sel_i[0])
            begin
                state_next.psv_en = wb_dat_i[SCPA_PSV_BIT];
            end
            else if (wb_adr_i == SCPA_OFS_STAT && wb_sel_i[0])
            begin
                // Write one to clear; a same-cycle error still sets
                state_next.ovf = state_reg.ovf && !wb_dat_i[0];
                state_next.unf = state_reg.unf && !wb_dat_i[1];
            end
        end
        // Untrapped stack ops override a same-cycle bus write of the pointer
        if (push_i)
        begin
            if (push_ovf || push_unf)
            begin
                state_next.trap = 1'b1;
                state_next.ovf = state_next.ovf || push_ovf;
                state_next.unf = state_next.unf || push_unf;
            end
            else
            begin
                state_next.mem_we = 1'b1;
                state_next.mem_addr = state_reg.sp;
                state_next.mem_wdata = push_word;
                state_next.sp = state_reg.sp + SCPA_WORD_STEP;
            end
        end
        else if (pop_i)
        begin
            if (pop_unf)
            begin
                state_next.trap = 1'b1;
                state_next.unf = 1'b1;
            end
            else
            begin
                state_next.mem_re = 1'b1;
                state_next.mem_addr = sp_dec;
                state_next.sp = sp_dec;
            end
        end
        // Program space addressing
        if (pa_req_i && pa_table_i)
        begin
            state_next.pa_valid = 1'b1;
            state_next.pa_addr = {state_reg.tblpg, pa_ea_i};
            if (pa_word_i)
            begin
                state_next.pa_addr[0] = 1'b0;
            end
            // Byte accesses keep bit 0 so every byte is reachable
            state_next.pa_cfg = state_reg.tblpg[SCPA_CFG_BIT];
            state_next.pa_refuse = pa_write_i
                && state_reg.tblpg[SCPA_CFG_BIT];
            state_next.pa_lsw = 1'b0;
        end
        else if (pa_req_i && psv_hit)
        begin
            state_next.pa_valid = 1'b1;
            // Page bit 0 lands on address bit 15
            state_next.pa_addr = {1'b0, state_reg.psvpg,
                pa_ea_i[14:1], 1'b0};
            state_next.pa_cfg = 1'b0;
            state_next.pa_refuse = pa_write_i;
            state_next.pa_lsw = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= '0;
            state_reg.sp <= SCPA_SP_RST;
            state_reg.tblpg <= SCPA_PAGE_RST;
            state_reg.psvpg <= SCPA_PAGE_RST;
            // Limit upper bits keep their value; bit 0 always reads zero
            state_reg.limit <= {state_reg.limit[15:1], 1'b0};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign wb_ack_o = state_reg.ack;
    assign wb_dat_o = state_reg.rdata;
    assign mem_we_o = state_reg.mem_we;
    assign mem_re_o = state_reg.mem_re;
    assign mem_addr_o = state_reg.mem_addr;
    assign mem_wdata_o = state_reg.mem_wdata;
    assign stack_err_trap_o = state_reg.trap;
    assign pa_valid_o = state_reg.pa_valid;
    assign pa_addr_o = state_reg.pa_addr;
    assign pa_cfg_o = state_reg.pa_cfg;
    assign pa_refuse_o = state_reg.pa_refuse;
    assign pa_lsw_only_o = state_reg.pa_lsw;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_PUSH_WRITES_SP: assert property (
        push_i && !push_ovf && !push_unf |=> mem_we_o
        && mem_addr_o == $past(state_reg.sp)
        && state_reg.sp == $past(state_reg.sp) + SCPA_WORD_STEP)
        else $error("push did not write at pointer then increment");
    AST_POP_PREDEC: assert property (
        !push_i && pop_i && !pop_unf |=> mem_re_o
        && mem_addr_o == $past(sp_dec) && state_reg.sp == mem_addr_o)
        else $error("pop did not decrement before read");
    AST_AT_LIMIT_OK: assert property (
        push_i && state_reg.sp == state_reg.limit && !push_unf
        |=> !stack_err_trap_o && mem_we_o)
        else $error("push at limit trapped");
    AST_OVER_LIMIT_TRAP: assert property (
        push_i && push_ovf |=> stack_err_trap_o && !mem_we_o)
        else $error("push past limit not trapped");
    AST_UNDERFLOW: assert property (
        !push_i && pop_i && state_reg.sp < 16'h0802
        |=> stack_err_trap_o && !mem_re_o)
        else $error("pop below floor not trapped");
    AST_LIMIT_ALIGNED: assert property (
        state_reg.limit[0] == 1'b0)
        else $error("limit bit 0 not zero");
    AST_CALL_ZERO_EXT: assert property (
        push_i && push_kind_i == SCPA_PUSH_CALL && !push_ovf
        && !push_unf |=> mem_wdata_o[15:8] == 8'h00)
        else $error("call push upper byte not clear");
    AST_TABLE_ADDR: assert property (
        pa_req_i && pa_table_i && !pa_word_i |=> pa_valid_o
        && pa_addr_o == {$past(state_reg.tblpg), $past(pa_ea_i)})
        else $error("table address wrong");
    AST_CFG_WRITE_REFUSED: assert property (
        pa_req_i && pa_table_i && pa_write_i && state_reg.tblpg[7]
        |=> pa_refuse_o && pa_cfg_o)
        else $error("config write not refused");
    AST_PSV_ADDR: assert property (
        pa_req_i && !pa_table_i && psv_hit |=> pa_valid_o
        && pa_addr_o[23] == 1'b0 && pa_addr_o[0] == 1'b0
        && pa_addr_o[15] == $past(state_reg.psvpg[0]) && pa_lsw_only_o)
        else $error("visibility address wrong");
    AST_NO_REMAP_OFF: assert property (
        pa_req_i && !pa_table_i && !state_reg.psv_en |=> !pa_valid_o)
        else $error("remap without enable");
    AST_ACK_ONE: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    COV_TRAP_OVF: cover property (push_i && push_ovf ##1 stack_err_trap_o);
    COV_AT_LIMIT: cover property (
        push_i && state_reg.sp == state_reg.limit ##1 mem_we_o
        ##[1:4] push_i && push_ovf);
    COV_PSV: cover property (pa_req_i && psv_hit ##1 pa_valid_o);
    COV_CFG_READ: cover property (
        pa_req_i && pa_table_i && !pa_write_i && state_reg.tblpg[7]);
endmodule
`default_nettype wire

// ### tb/scpa_stack_mem.sv
// Stack memory model facing the block's stack port.
// Assumes one-cycle registered write and read strobes from the block.
`timescale 1ns/1ps
`default_nettype none
module scpa_stack_mem
(
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic re_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] rdata_o
);
    logic [15:0] mem [0:255];
    // Idle data inverts each cycle, so a stale word matches again after every second idle cycle
    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem[addr_i[8:1]] <= wdata_i;
        end
        rdata_o <= re_i ? mem[addr_i[8:1]] : ~rdata_o;
    end
endmodule
`default_nettype wire

// ### tb/scpa_top_tb.sv
// Self-checking bench for the stack check and program address block.
// Assumes a 10 MHz clock and the stack memory model beside the block.
`timescale 1ns/1ps
`default_nettype none
module scpa_top_tb;
    import scpa_pkg::*;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = 0, status_low_byte_i = 8'h5a;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 0, wb_dat_o, rdv;
    logic wb_ack_o, push_i = 0, pop_i = 0, pa_req_i = 0, pa_table_i = 0;
    logic [1:0] push_kind_i = 0;
    logic [15:0] push_data_i = 0, pa_ea_i = 0, mem_addr_o, mem_wdata_o, rdata;
    logic mem_we_o, mem_re_o, stack_err_trap_o, pa_write_i = 0, pa_word_i = 0;
    logic pa_valid_o, pa_cfg_o, pa_refuse_o, pa_lsw_only_o;
    logic [23:0] pa_addr_o;
    int miscompares = 0, check_count = 0;
    always #50 clk_i = ~clk_i;
    scpa_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .push_i(push_i), .push_kind_i(push_kind_i),
        .push_data_i(push_data_i), .status_low_byte_i(status_low_byte_i),
        .pop_i(pop_i), .mem_we_o(mem_we_o), .mem_re_o(mem_re_o),
        .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
        .stack_err_trap_o(stack_err_trap_o), .pa_req_i(pa_req_i),
        .pa_table_i(pa_table_i), .pa_write_i(pa_write_i),
        .pa_word_i(pa_word_i), .pa_ea_i(pa_ea_i), .pa_valid_o(pa_valid_o),
        .pa_addr_o(pa_addr_o), .pa_cfg_o(pa_cfg_o),
        .pa_refuse_o(pa_refuse_o), .pa_lsw_only_o(pa_lsw_only_o));
    scpa_stack_mem i_mem (.clk_i(clk_i), .we_i(mem_we_o), .re_i(mem_re_o),
        .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(rdata));
    task automatic chk(input string what, input logic [23:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] adr,
        input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        rdv = wb_dat_o;
        chk("wb ack", 24'(wb_ack_o), 24'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] adr, input logic [15:0] exp);
        wb(1'b0, adr, 32'h0);
        chk("reg read", rdv[23:0], 24'(exp));
    endtask
    // Strobes last one cycle; outputs sampled just after the answer edge
    task automatic stk(input logic psh, input logic [1:0] k,
        input logic [15:0] d);
        @(posedge clk_i);
        push_i <= psh;
        pop_i <= ~psh;
        push_kind_i <= k;
        push_data_i <= d;
        @(posedge clk_i);
        push_i <= 1'b0;
        pop_i <= 1'b0;
        #1;
    endtask
    task automatic pa(input logic t, w, wd, input logic [15:0] ea);
        @(posedge clk_i);
        pa_req_i <= 1'b1;
        pa_table_i <= t;
        pa_write_i <= w;
        pa_word_i <= wd;
        pa_ea_i <= ea;
        @(posedge clk_i);
        pa_req_i <= 1'b0;
        #1;
    endtask
    task automatic t_regs();
        rd_chk(SCPA_OFS_SP, SCPA_SP_RST);
        rd_chk(SCPA_OFS_TBLPG, 16'h0000);
        rd_chk(SCPA_OFS_PSVPG, 16'h0000);
        rd_chk(SCPA_OFS_CORE, 16'h0000);
        rd_chk(SCPA_OFS_STAT, 16'h0000);
        wb(1'b1, SCPA_OFS_LIMIT, 32'h1fff);
        rd_chk(SCPA_OFS_LIMIT, 16'h1ffe);
        rd_chk(8'h20, 16'h0000);
        $display("test regs done");
    endtask
    task automatic t_push();
        wb(1'b1, SCPA_OFS_LIMIT, 32'h0802);
        stk(1'b1, SCPA_PUSH_DATA, 16'hbeef);
        chk("push we", 24'(mem_we_o), 24'h1);
        chk("push addr", 24'(mem_addr_o), 24'h0800);
        chk("push data", 24'(mem_wdata_o), 24'hbeef);
        stk(1'b1, SCPA_PUSH_CALL, 16'hab12);
        chk("limit push", 24'(mem_addr_o), 24'h0802);
        chk("call data", 24'(mem_wdata_o), 24'h0012);
        stk(1'b1, SCPA_PUSH_EXC, 16'h0001);
        chk("ovf trap", 24'(stack_err_trap_o), 24'h1);
        chk("ovf no write", 24'(mem_we_o), 24'h0);
        rd_chk(SCPA_OFS_SP, 16'h0804);
        rd_chk(SCPA_OFS_STAT, 16'h0001);
        wb(1'b1, SCPA_OFS_STAT, 32'h3);
        rd_chk(SCPA_OFS_STAT, 16'h0000);
        wb(1'b1, SCPA_OFS_LIMIT, 32'h0900);
        stk(1'b1, SCPA_PUSH_EXC, 16'hff34);
        chk("exc data", 24'(mem_wdata_o), 24'h5a34);
        $display("test push done");
    endtask
    task automatic t_pop();
        logic [15:0] exp [3];
        exp = '{16'h5a34, 16'h0012, 16'hbeef};
        // An idle cycle lets the memory model's registered read return the popped word
        for (int i = 0; i < 3; i++)
        begin
            stk(1'b0, SCPA_PUSH_DATA, 16'h0);
            chk("pop re", 24'(mem_re_o), 24'h1);
            chk("pop addr", 24'(mem_addr_o), 24'(16'h0804 - 2 * i));
            @(posedge clk_i);
            #1;
            chk("pop data", 24'(rdata), 24'(exp[i]));
        end
        stk(1'b0, SCPA_PUSH_DATA, 16'h0);
        chk("unf trap", 24'(stack_err_trap_o), 24'h1);
        chk("unf no read", 24'(mem_re_o), 24'h0);
        rd_chk(SCPA_OFS_STAT, 16'h0002);
        wb(1'b1, SCPA_OFS_SP, 32'h07ff);
        rd_chk(SCPA_OFS_SP, 16'h07fe);
        stk(1'b1, SCPA_PUSH_DATA, 16'h1111);
        chk("low push trap", 24'(stack_err_trap_o), 24'h1);
        chk("low no write", 24'(mem_we_o), 24'h0);
        $display("test pop done");
    endtask
    task automatic t_table();
        logic [7:0] pg [4];
        pg = '{8'h00, 8'h05, 8'h80, 8'hff};
        for (int i = 0; i < 4; i++)
        begin
            wb(1'b1, SCPA_OFS_TBLPG, 32'(pg[i]));
            pa(1'b1, 1'b0, 1'b0, 16'h1235);
            chk("tbl valid", 24'(pa_valid_o), 24'h1);
            chk("tbl addr", pa_addr_o, {pg[i], 16'h1235});
            chk("tbl cfg", 24'(pa_cfg_o), 24'(pg[i][7]));
            chk("tbl rd ok", 24'(pa_refuse_o), 24'h0);
            chk("tbl all", 24'(pa_lsw_only_o), 24'h0);
            pa(1'b1, 1'b0, 1'b1, 16'h1235);
            chk("tbl word", pa_addr_o, {pg[i], 16'h1234});
            pa(1'b1, 1'b1, 1'b1, 16'h8000);
            chk("tbl wr", 24'(pa_refuse_o), 24'(pg[i][7]));
        end
        $display("test table done");
    endtask
    task automatic t_psv();
        wb(1'b1, SCPA_OFS_PSVPG, 32'h83);
        pa(1'b0, 1'b0, 1'b1, 16'h9235);
        chk("psv off", 24'(pa_valid_o), 24'h0);
        wb(1'b1, SCPA_OFS_CORE, 32'h1 << SCPA_PSV_BIT);
        pa(1'b0, 1'b0, 1'b0, 16'h9235);
        chk("psv valid", 24'(pa_valid_o), 24'h1);
        chk("psv addr", pa_addr_o, 24'h419234);
        chk("psv user", 24'(pa_cfg_o), 24'h0);
        chk("psv lsw", 24'(pa_lsw_only_o), 24'h1);
        pa(1'b0, 1'b0, 1'b1, 16'h1235);
        chk("psv low ea", 24'(pa_valid_o), 24'h0);
        pa(1'b0, 1'b1, 1'b1, 16'h9234);
        chk("psv write", 24'(pa_refuse_o), 24'h1);
        $display("test psv done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Whole run takes under two hundred cycles; wide margin before cutting
    initial
    begin
        repeat (5000) @(posedge clk_i);
        miscompares++;
        conclude();
    end
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_push();
        t_pop();
        t_table();
        t_psv();
        conclude();
    end
endmodule
`default_nettype wire
